/* shared/mis_defs.svh */
// Purpose: Constants for the instruction execution core.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Field ranges are used as wd[`MIS_F_xxx].
`ifndef MIS_DEFS_SVH
`define MIS_DEFS_SVH

// Register word indices decoded on address bits 4:2
`define MIS_REG_EXEC    3'h0
`define MIS_REG_ACC     3'h1
`define MIS_REG_STATUS  3'h2
`define MIS_REG_PC      3'h3
`define MIS_REG_MADDR   3'h4
`define MIS_REG_MDATA   3'h5
`define MIS_REG_WAKE    3'h6
`define MIS_REG_WDT     3'h7

// Instruction word fields
`define MIS_F_OP        5:0
`define MIS_F_OPND      15:8
`define MIS_F_TARGET    18:8
`define MIS_F_BIT       22:20

// Status register bit positions
`define MIS_ST_C        0
`define MIS_ST_AC       1
`define MIS_ST_Z        2
`define MIS_ST_OV       3
`define MIS_ST_PDF      4
`define MIS_ST_TO       5
`define MIS_ST_GIE      6
`define MIS_ST_HALT     7

// Reset values and fixed constants
`define MIS_PC_RST      11'h000
`define MIS_IRQ_VECTOR  11'h004
`define MIS_BCD_LIMIT   4'h9
`define MIS_BCD_LO      8'h06
`define MIS_BCD_HI      8'h60
`define MIS_BYTE_ZERO   8'h00
`define MIS_BYTE_ONE    8'h01

`endif

/* shared/mis_pkg.sv */
// Purpose: Types for the instruction execution core.
// Assumes: Opcode codes follow the enum order, starting at zero.
// Notes:   Codes 32..63 are illegal and execute as idle.
package mis_pkg;

  typedef enum logic [5:0] {
    OP_IDLE, OP_SUMC_ACC, OP_SUMC_MEM, OP_SUM_ACC, OP_SUM_IMM, OP_SUM_MEM,
    OP_CONJ_ACC, OP_CONJ_IMM, OP_CONJ_MEM, OP_DISJ_ACC, OP_DISJ_IMM,
    OP_DISJ_MEM, OP_CALL, OP_ZERO_FILL, OP_ZERO_BIT, OP_WDT_CLEAR,
    OP_INVERT_MEM, OP_INVERT_ACC, OP_BCD_ADJUST, OP_MINUS_MEM,
    OP_MINUS_ACC, OP_HALT, OP_PLUS_MEM, OP_PLUS_ACC, OP_BRANCH,
    OP_COPY_TO_ACC, OP_COPY_TO_MEM, OP_COPY_IMM, OP_SUB_EXIT,
    OP_SUB_EXIT_LIT, OP_ISR_EXIT, OP_ROTATE_LEFT
  } mis_op_t;

  typedef enum logic {ST_IDLE, ST_SECOND} mis_state_t;

  typedef struct packed {
    mis_state_t  st;
    mis_op_t     op_q;
    logic [7:0]  acc;
    logic [10:0] pc;
    logic        c;
    logic        ac;
    logic        z;
    logic        ov;
    logic        sleep_entered_flag;
    logic        to;
    logic        gie;
    logic        halted;
    logic [2:0]  sp;
    logic [7:0]  mem_addr;
    logic [7:0]  wdt;
    logic [7:0]  presc;
    logic [2:0]  irq_sync;
    logic        irq_pend;
    logic        busy;
    logic [31:0] rdata;
    logic        irq_ack;
    logic        clk_run;
  } mis_regs_t;

endpackage

/* hw/mis_core.sv */
// Purpose: Executes one instruction per EXEC write over Avalon-MM.
// Assumes: irq_req_i is asynchronous; all else on ref_clk_i.
// Notes:   Two-cycle ops hold waitrequest one extra cycle.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mis_defs.svh"

module mis_core
  import mis_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic        irq_req_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             clk_run_o,
  output logic             irq_ack_o
);

  mis_regs_t   r_reg;
  mis_regs_t   r_next;
  logic [7:0]  dmem [256];
  logic [10:0] stack [8];

  logic        start;
  logic        wr;
  logic [2:0]  ridx;
  mis_op_t     op;
  logic [7:0]  opnd;
  logic [10:0] target;
  logic [2:0]  bidx;
  logic [7:0]  mrd;
  logic [7:0]  bsel;
  logic        cin;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic        ovf;
  logic [8:0]  bcd_lo;
  logic        bcd_hi_adj;
  logic [7:0]  bcd_res;
  logic        dm_we;
  logic [7:0]  dm_waddr;
  logic [7:0]  dm_wdata;
  logic        stk_we;
  logic [10:0] stk_wdata;

  assign start  = (avs_read_i | avs_write_i) & r_reg.busy
                  & (r_reg.st == ST_IDLE);
  assign wr     = start & avs_write_i;
  assign ridx   = avs_address_i[4:2];
  assign op     = mis_op_t'(avs_writedata_i[`MIS_F_OP]);
  assign opnd   = avs_writedata_i[`MIS_F_OPND];
  assign target = avs_writedata_i[`MIS_F_TARGET];
  assign bidx   = avs_writedata_i[`MIS_F_BIT];
  assign mrd    = dmem[opnd];

  // Operand B is the immediate for immediate forms, else the memory byte
  assign bsel  = (op == OP_SUM_IMM || op == OP_CONJ_IMM ||
                  op == OP_DISJ_IMM) ? opnd : mrd;
  assign cin   = (op == OP_SUMC_ACC || op == OP_SUMC_MEM) & r_reg.c;
  assign sum9  = {1'b0, r_reg.acc} + {1'b0, bsel} + {8'h00, cin};
  assign half5 = {1'b0, r_reg.acc[3:0]} + {1'b0, bsel[3:0]}
                 + {4'h0, cin};
  assign ovf   = (r_reg.acc[7] == bsel[7]) & (sum9[7] != r_reg.acc[7]);

  // Decimal adjust works on the accumulator and stores into memory
  assign bcd_lo = {1'b0, r_reg.acc} +
                  {1'b0, ((r_reg.acc[3:0] > `MIS_BCD_LIMIT) || r_reg.ac)
                         ? `MIS_BCD_LO : `MIS_BYTE_ZERO};
  assign bcd_hi_adj = (bcd_lo[7:4] > `MIS_BCD_LIMIT) || r_reg.c
                      || bcd_lo[8];
  assign bcd_res = bcd_lo[7:0] +
                   (bcd_hi_adj ? `MIS_BCD_HI : `MIS_BYTE_ZERO);

  always_comb begin
    r_next        = r_reg;
    r_next.busy   = 1'b1;
    r_next.irq_ack = 1'b0;
    dm_we         = 1'b0;
    dm_waddr      = opnd;
    dm_wdata      = `MIS_BYTE_ZERO;
    stk_we        = 1'b0;
    stk_wdata     = r_reg.pc + 11'h001;
    r_next.irq_sync = {r_reg.irq_sync[1:0], irq_req_i};

    // Watchdog prescaler and counter free-run
    r_next.presc = r_reg.presc + `MIS_BYTE_ONE;
    if (&r_reg.presc) begin
      r_next.wdt = r_reg.wdt + `MIS_BYTE_ONE;
      if (&r_reg.wdt) begin
        r_next.to = 1'b1;
      end
    end

    if (r_reg.st == ST_SECOND) begin
      // Dummy cycle of a two-cycle op; answer goes out now
      r_next.st   = ST_IDLE;
      r_next.busy = 1'b0;
      if (r_reg.op_q == OP_ISR_EXIT && r_reg.irq_pend) begin
        stk_we         = 1'b1;
        stk_wdata      = r_reg.pc;
        r_next.sp      = r_reg.sp + 3'h1;
        r_next.pc      = `MIS_IRQ_VECTOR;
        r_next.gie     = 1'b0;
        r_next.irq_pend = 1'b0;
        r_next.irq_ack = 1'b1;
      end
    end else if (start) begin
      r_next.busy  = 1'b0;
      r_next.rdata = 32'h0000_0000;
      if (!wr) begin
        unique case (ridx)
          `MIS_REG_EXEC:   r_next.rdata = {26'h000_0000, r_reg.op_q};
          `MIS_REG_ACC:    r_next.rdata = {24'h00_0000, r_reg.acc};
          `MIS_REG_STATUS: r_next.rdata = {24'h00_0000, r_reg.halted,
                             r_reg.gie, r_reg.to, r_reg.sleep_entered_flag, r_reg.ov,
                             r_reg.z, r_reg.ac, r_reg.c};
          `MIS_REG_PC:     r_next.rdata = {21'h00_0000, r_reg.pc};
          `MIS_REG_MADDR:  r_next.rdata = {24'h00_0000, r_reg.mem_addr};
          `MIS_REG_MDATA:  r_next.rdata = {24'h00_0000,
                                           dmem[r_reg.mem_addr]};
          `MIS_REG_WAKE:   r_next.rdata = 32'h0000_0000;
          `MIS_REG_WDT:    r_next.rdata = {24'h00_0000, r_reg.wdt};
        endcase
      end else if (ridx == `MIS_REG_EXEC) begin
        // Issued while halted or with any of lanes 0-2 disabled: acknowledged, ignored
        if (!r_reg.halted && (&avs_byteenable_i[2:0])) begin
          r_next.op_q = op;
          r_next.pc   = r_reg.pc + 11'h001;
          unique case (op)
            OP_SUMC_ACC, OP_SUM_ACC, OP_SUM_IMM: begin
              r_next.acc = sum9[7:0];
              r_next.c   = sum9[8];
              r_next.ac  = half5[4];
              r_next.ov  = ovf;
              r_next.z   = (sum9[7:0] == `MIS_BYTE_ZERO);
            end
            OP_SUMC_MEM, OP_SUM_MEM: begin
              dm_we     = 1'b1;
              dm_wdata  = sum9[7:0];
              r_next.c  = sum9[8];
              r_next.ac = half5[4];
              r_next.ov = ovf;
              r_next.z  = (sum9[7:0] == `MIS_BYTE_ZERO);
            end
            OP_CONJ_ACC, OP_CONJ_IMM: begin
              r_next.acc = r_reg.acc & bsel;
              r_next.z   = ((r_reg.acc & bsel) == `MIS_BYTE_ZERO);
            end
            OP_CONJ_MEM: begin
              dm_we    = 1'b1;
              dm_wdata = r_reg.acc & mrd;
              r_next.z = ((r_reg.acc & mrd) == `MIS_BYTE_ZERO);
            end
            OP_DISJ_ACC, OP_DISJ_IMM: begin
              r_next.acc = r_reg.acc | bsel;
              r_next.z   = ((r_reg.acc | bsel) == `MIS_BYTE_ZERO);
            end
            OP_DISJ_MEM: begin
              dm_we    = 1'b1;
              dm_wdata = r_reg.acc | mrd;
              r_next.z = ((r_reg.acc | mrd) == `MIS_BYTE_ZERO);
            end
            OP_CALL: begin
              stk_we    = 1'b1;
              r_next.sp = r_reg.sp + 3'h1;
              r_next.pc = target;
              r_next.st = ST_SECOND;
              r_next.busy = 1'b1;
            end
            OP_ZERO_FILL: begin
              dm_we    = 1'b1;
              dm_wdata = `MIS_BYTE_ZERO;
            end
            OP_ZERO_BIT: begin
              dm_we    = 1'b1;
              dm_wdata = mrd & ~(`MIS_BYTE_ONE << bidx);
            end
            OP_WDT_CLEAR: begin
              r_next.wdt   = `MIS_BYTE_ZERO;
              r_next.presc = `MIS_BYTE_ZERO;
              r_next.to    = 1'b0;
              r_next.sleep_entered_flag   = 1'b0;
            end
            OP_INVERT_MEM: begin
              dm_we    = 1'b1;
              dm_wdata = ~mrd;
              r_next.z = (mrd == 8'hFF);
            end
            OP_INVERT_ACC: begin
              r_next.acc = ~mrd;
              r_next.z   = (mrd == 8'hFF);
            end
            OP_BCD_ADJUST: begin
              dm_we    = 1'b1;
              dm_wdata = bcd_res;
              if (bcd_hi_adj) begin
                r_next.c = 1'b1;
              end
            end
            OP_MINUS_MEM: begin
              dm_we    = 1'b1;
              dm_wdata = mrd - `MIS_BYTE_ONE;
              r_next.z = (mrd == `MIS_BYTE_ONE);
            end
            OP_MINUS_ACC: begin
              r_next.acc = mrd - `MIS_BYTE_ONE;
              r_next.z   = (mrd == `MIS_BYTE_ONE);
            end
            OP_HALT: begin
              r_next.halted  = 1'b1;
              r_next.clk_run = 1'b0;
              r_next.wdt     = `MIS_BYTE_ZERO;
              r_next.presc   = `MIS_BYTE_ZERO;
              r_next.sleep_entered_flag     = 1'b1;
              r_next.to      = 1'b0;
            end
            OP_PLUS_MEM: begin
              dm_we    = 1'b1;
              dm_wdata = mrd + `MIS_BYTE_ONE;
              r_next.z = (mrd == 8'hFF);
            end
            OP_PLUS_ACC: begin
              r_next.acc = mrd + `MIS_BYTE_ONE;
              r_next.z   = (mrd == 8'hFF);
            end
            OP_BRANCH: begin
              r_next.pc   = target;
              r_next.st   = ST_SECOND;
              r_next.busy = 1'b1;
            end
            OP_COPY_TO_ACC: r_next.acc = mrd;
            OP_COPY_IMM:    r_next.acc = opnd;
            OP_COPY_TO_MEM: begin
              dm_we    = 1'b1;
              dm_wdata = r_reg.acc;
            end
            OP_SUB_EXIT, OP_SUB_EXIT_LIT, OP_ISR_EXIT: begin
              r_next.sp   = r_reg.sp - 3'h1;
              r_next.pc   = stack[r_reg.sp - 3'h1];
              r_next.st   = ST_SECOND;
              r_next.busy = 1'b1;
              if (op == OP_SUB_EXIT_LIT) begin
                r_next.acc = opnd;
              end
              if (op == OP_ISR_EXIT) begin
                r_next.gie = 1'b1;
              end
            end
            OP_ROTATE_LEFT: begin
              dm_we    = 1'b1;
              dm_wdata = {mrd[6:0], mrd[7]};
            end
            OP_IDLE: r_next.pc = r_reg.pc + 11'h001;
            default: r_next.op_q = OP_IDLE;
          endcase
        end
      end else begin
        unique case (ridx)
          `MIS_REG_ACC:    r_next.acc = avs_writedata_i[7:0];
          `MIS_REG_STATUS: begin
            r_next.c   = avs_writedata_i[`MIS_ST_C];
            r_next.ac  = avs_writedata_i[`MIS_ST_AC];
            r_next.z   = avs_writedata_i[`MIS_ST_Z];
            r_next.ov  = avs_writedata_i[`MIS_ST_OV];
            r_next.gie = avs_writedata_i[`MIS_ST_GIE];
          end
          `MIS_REG_PC:     r_next.pc = avs_writedata_i[10:0];
          `MIS_REG_MADDR:  r_next.mem_addr = avs_writedata_i[7:0];
          `MIS_REG_MDATA: begin
            dm_we    = avs_byteenable_i[0];
            dm_waddr = r_reg.mem_addr;
            dm_wdata = avs_writedata_i[7:0];
          end
          `MIS_REG_WAKE: begin
            r_next.halted  = r_reg.halted & ~avs_writedata_i[0];
            r_next.clk_run = r_reg.clk_run | avs_writedata_i[0];
          end
          default: r_next.busy = 1'b0;
        endcase
      end
    end else if (r_reg.irq_pend && r_reg.halted) begin
      // A pending request wakes the core from power-down
      r_next.halted  = 1'b0;
      r_next.clk_run = 1'b1;
    end else if (r_reg.irq_pend && r_reg.gie && r_reg.busy) begin
      stk_we          = 1'b1;
      stk_wdata       = r_reg.pc;
      r_next.sp       = r_reg.sp + 3'h1;
      r_next.pc       = `MIS_IRQ_VECTOR;
      r_next.gie      = 1'b0;
      r_next.irq_pend = 1'b0;
      r_next.irq_ack  = 1'b1;
    end

    // New request edge beats a service clear; a held level pends once
    if (r_reg.irq_sync[1] && !r_reg.irq_sync[2]) begin
      r_next.irq_pend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg         <= '0;
      r_reg.pc      <= `MIS_PC_RST;
      r_reg.busy    <= 1'b1;
      r_reg.clk_run <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (dm_we) begin
      dmem[dm_waddr] <= dm_wdata;
    end
    if (stk_we) begin
      stack[r_reg.sp] <= stk_wdata;
    end
  end

  assign avs_readdata_o    = r_reg.rdata;
  assign avs_waitrequest_o = r_reg.busy;
  assign clk_run_o         = r_reg.clk_run;
  assign irq_ack_o         = r_reg.irq_ack;
  logic ex;
  assign ex = wr && ridx == `MIS_REG_EXEC && !r_reg.halted
              && (&avs_byteenable_i[2:0]);

  sum_flags_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_SUM_IMM) |=> r_reg.acc == $past(sum9[7:0])
      && r_reg.c == $past(sum9[8]) && r_reg.ac == $past(half5[4]))
    else $error("sum result or flags wrong");
  sumc_mem_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_SUMC_MEM) |=> dmem[$past(opnd)] ==
      8'($past(r_reg.acc) + $past(mrd) + {7'h00, $past(r_reg.c)}))
    else $error("carry sum not stored");
  conj_zero_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_CONJ_ACC) |=> r_reg.z == (r_reg.acc == 8'h00)
      && $stable(r_reg.c) && $stable(r_reg.ov))
    else $error("conjunction flags wrong");
  call_two_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_CALL) |=> r_reg.busy && r_reg.pc == $past(target)
      && stack[$past(r_reg.sp)] == $past(r_reg.pc) + 11'h001
      ##1 !r_reg.busy)
    else $error("call push or timing wrong");
  branch_two_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_BRANCH) |=> r_reg.busy[*1] ##1 !r_reg.busy
      && $stable(r_reg.z))
    else $error("branch not two cycles");
  wdt_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_WDT_CLEAR) |=> r_reg.wdt == 8'h00 && !r_reg.to
      && !r_reg.sleep_entered_flag)
    else $error("watchdog clear incomplete");
  halt_stop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_HALT) |=> !clk_run_o && r_reg.sleep_entered_flag && !r_reg.to
      && r_reg.halted)
    else $error("halt did not stop clock");
  isr_gie_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_ISR_EXIT) |=> r_reg.gie)
    else $error("global enable not restored");
  isr_pend_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_ISR_EXIT && r_reg.irq_pend) |=> ##1
      r_reg.pc == 11'h004 && irq_ack_o)
    else $error("pending request not served");
  rotate_mem_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ex && op == OP_ROTATE_LEFT) |=> dmem[$past(opnd)] ==
      {$past(mrd[6:0]), $past(mrd[7])} && $stable(r_reg.c))
    else $error("rotate result wrong");

endmodule

/* verification/mis_irq_src.sv */
// Purpose: Interrupt source standing at the core's far side.
// Assumes: raise_i is a one-cycle pulse from the bench.
// Notes:   Holds the request until the core acknowledges it.
`timescale 1ns/1ps

module mis_irq_src (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       raise_i,
  input  wire logic       irq_ack_i,
  output logic            irq_req_o,
  output logic [3:0]      ack_cnt_o
);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_req_o <= 1'b0;
      ack_cnt_o <= 4'h0;
    end else begin
      if (raise_i) begin
        irq_req_o <= 1'b1;
      end else if (irq_ack_i) begin
        irq_req_o <= 1'b0;
      end
      if (irq_ack_i) begin
        ack_cnt_o <= ack_cnt_o + 4'h1;
      end
    end
  end
endmodule

/* verification/mis_core_tb.sv */
// Purpose: Self-checking bench for the instruction core.
// Assumes: Avalon-MM master holds each request until waitrequest low.
// Notes:   Expected results come from a local reference model.
`timescale 1ns/1ps
`include "mis_defs.svh"

module mis_core_tb
  import mis_pkg::*;
  ;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic        raise = 1'b0;
  logic        irq_req;
  logic [31:0] rdat;
  logic        wait_r;
  logic        clk_run;
  logic        irq_ack;
  logic [3:0]  ack_cnt;
  logic [31:0] got;
  int          lat;
  int          err_total = 0;
  int          checked = 0;

  always #20 clk = ~clk;

  mis_core DUT (
    .ref_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .irq_req_i(irq_req), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_r), .clk_run_o(clk_run), .irq_ack_o(irq_ack)
  );

  mis_irq_src partner (
    .ref_clk_i(clk), .rst_i(rst), .raise_i(raise), .irq_ack_i(irq_ack),
    .irq_req_o(irq_req), .ack_cnt_o(ack_cnt)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon transfer; lat counts cycles from take to answer
  task automatic bus(input logic w, input logic [2:0] r,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {r, 2'b00};
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    got = rdat;
    lat = n - 1;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] waitrequest expected low seen high");
    end
  endtask

  task automatic wreg(input logic [2:0] r, input logic [31:0] d);
    bus(1'b1, r, d);
  endtask

  task automatic rchk(input string nm, input logic [2:0] r,
                      input logic [31:0] e);
    bus(1'b0, r, 32'h0000_0000);
    chk(nm, e, got);
  endtask

  task automatic exec(input mis_op_t op, input logic [10:0] t);
    bus(1'b1, `MIS_REG_EXEC, {9'h000, 3'h5, 1'b0, t, 2'b00, op});
  endtask

  // Returns {acc, mem, ov z ac c} after one op; bit field fixed at 5
  function automatic logic [19:0] ref_op(input mis_op_t op,
      input logic [7:0] a, input logic [7:0] m, input logic [3:0] fi);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic [3:0] f;
    logic       ci;
    logic       tm;
    f = fi;
    r = a;
    ci = (op == OP_SUMC_ACC || op == OP_SUMC_MEM) ? fi[0] : 1'b0;
    s = a + m + ci;
    h = a[3:0] + m[3:0] + ci;
    tm = op inside {OP_SUMC_MEM, OP_SUM_MEM, OP_CONJ_MEM, OP_DISJ_MEM,
      OP_ZERO_FILL, OP_ZERO_BIT, OP_INVERT_MEM, OP_BCD_ADJUST,
      OP_MINUS_MEM, OP_PLUS_MEM, OP_COPY_TO_MEM, OP_ROTATE_LEFT};
    case (op)
      OP_SUMC_ACC, OP_SUMC_MEM, OP_SUM_ACC, OP_SUM_IMM, OP_SUM_MEM: r = s[7:0];
      OP_CONJ_ACC, OP_CONJ_IMM, OP_CONJ_MEM: r = a & m;
      OP_DISJ_ACC, OP_DISJ_IMM, OP_DISJ_MEM: r = a | m;
      OP_ZERO_FILL: r = 8'h00;
      OP_ZERO_BIT: r = m & 8'hDF;
      OP_INVERT_MEM, OP_INVERT_ACC: r = ~m;
      OP_MINUS_MEM, OP_MINUS_ACC: r = m - 8'h01;
      OP_PLUS_MEM, OP_PLUS_ACC: r = m + 8'h01;
      OP_COPY_TO_ACC, OP_COPY_IMM: r = m;
      OP_ROTATE_LEFT: r = {m[6:0], m[7]};
      OP_BCD_ADJUST: r = a + ((a[3:0] > 4'h9 || fi[1]) ? 8'h06 : 8'h00)
                         + ((a[7:4] > 4'h9 || fi[0]) ? 8'h60 : 8'h00);
      default: r = a;
    endcase
    if (op inside {[OP_SUMC_ACC:OP_SUM_MEM]}) begin
      f = {(a[7] == m[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
    end
    if (op inside {[OP_CONJ_ACC:OP_DISJ_MEM], OP_INVERT_MEM, OP_INVERT_ACC,
                   OP_MINUS_MEM, OP_MINUS_ACC, OP_PLUS_MEM, OP_PLUS_ACC}) begin
      f[2] = (r == 8'h00);
    end
    if (op == OP_BCD_ADJUST && (a[7:4] > 4'h9 || fi[0])) begin
      f[0] = 1'b1;
    end
    return {tm ? a : r, tm ? r : m, f};
  endfunction

  task automatic alu(input mis_op_t op, input logic [7:0] a,
                     input logic [7:0] m, input logic [3:0] f);
    logic [19:0] e;
    logic [7:0]  o;
    e = ref_op(op, a, m, f);
    o = (op inside {OP_SUM_IMM, OP_CONJ_IMM, OP_DISJ_IMM, OP_COPY_IMM})
        ? m : 8'h10;
    wreg(`MIS_REG_ACC, {24'h00_0000, a});
    wreg(`MIS_REG_MADDR, 32'h0000_0010);
    wreg(`MIS_REG_MDATA, {24'h00_0000, m});
    wreg(`MIS_REG_STATUS, {28'h000_0000, f});
    exec(op, {3'h0, o});
    chk("lat", 32'h0000_0001, lat);
    rchk("acc", `MIS_REG_ACC, {24'h00_0000, e[19:12]});
    rchk("mem", `MIS_REG_MDATA, {24'h00_0000, e[11:4]});
    rchk("status", `MIS_REG_STATUS, {28'h000_0000, e[3:0]});
  endtask

  task automatic t_alu();
    alu(OP_SUMC_ACC, 8'hFF, 8'h00, 4'h1);
    alu(OP_SUMC_MEM, 8'h3F, 8'h40, 4'h1);
    alu(OP_SUM_ACC, 8'h7F, 8'h01, 4'h1);
    alu(OP_SUM_IMM, 8'h88, 8'h88, 4'h0);
    alu(OP_SUM_MEM, 8'h12, 8'h34, 4'hF);
    alu(OP_CONJ_ACC, 8'hF0, 8'h0F, 4'hB);
    alu(OP_CONJ_IMM, 8'h3C, 8'h0F, 4'hF);
    alu(OP_CONJ_MEM, 8'hAA, 8'hFF, 4'h4);
    alu(OP_DISJ_ACC, 8'h00, 8'h00, 4'h0);
    alu(OP_DISJ_IMM, 8'h50, 8'h05, 4'hF);
    alu(OP_DISJ_MEM, 8'h01, 8'h80, 4'h4);
    alu(OP_ZERO_FILL, 8'h11, 8'hA5, 4'hF);
    alu(OP_ZERO_BIT, 8'h11, 8'hFF, 4'hA);
    alu(OP_INVERT_MEM, 8'h22, 8'hFF, 4'hB);
    alu(OP_INVERT_ACC, 8'h22, 8'h5A, 4'hF);
    alu(OP_BCD_ADJUST, 8'h3C, 8'h00, 4'h0);
    alu(OP_BCD_ADJUST, 8'hA7, 8'h00, 4'h2);
    alu(OP_BCD_ADJUST, 8'h15, 8'h00, 4'h1);
    alu(OP_MINUS_MEM, 8'h33, 8'h01, 4'hB);
    alu(OP_MINUS_ACC, 8'h33, 8'h00, 4'h4);
    alu(OP_PLUS_MEM, 8'h44, 8'hFF, 4'h0);
    alu(OP_PLUS_ACC, 8'h44, 8'h7F, 4'h4);
    alu(OP_COPY_TO_ACC, 8'h00, 8'h9C, 4'hF);
    alu(OP_COPY_TO_MEM, 8'hC3, 8'h00, 4'h5);
    alu(OP_COPY_IMM, 8'h21, 8'h6B, 4'hA);
    alu(OP_ROTATE_LEFT, 8'h00, 8'h81, 4'hF);
    alu(OP_IDLE, 8'h5E, 8'h6F, 4'h9);
  endtask

  task automatic t_flow();
    wreg(`MIS_REG_STATUS, 32'h0000_0005);
    wreg(`MIS_REG_PC, 32'h0000_0020);
    exec(OP_IDLE, 11'h000);
    rchk("pc", `MIS_REG_PC, 32'h0000_0021);
    exec(OP_CALL, 11'h155);
    chk("lat", 32'h0000_0002, lat);
    rchk("pc", `MIS_REG_PC, 32'h0000_0155);
    exec(OP_BRANCH, 11'h2AB);
    chk("lat", 32'h0000_0002, lat);
    rchk("pc", `MIS_REG_PC, 32'h0000_02AB);
    exec(OP_SUB_EXIT, 11'h000);
    rchk("pc", `MIS_REG_PC, 32'h0000_0022);
    exec(OP_CALL, 11'h100);
    exec(OP_SUB_EXIT_LIT, 11'h05A);
    rchk("pc", `MIS_REG_PC, 32'h0000_0023);
    rchk("acc", `MIS_REG_ACC, 32'h0000_005A);
    rchk("status", `MIS_REG_STATUS, 32'h0000_0005);
  endtask

  task automatic t_isr();
    wreg(`MIS_REG_STATUS, 32'h0000_0000);
    wreg(`MIS_REG_PC, 32'h0000_0040);
    exec(OP_CALL, 11'h300);
    exec(OP_ISR_EXIT, 11'h000);
    rchk("pc", `MIS_REG_PC, 32'h0000_0041);
    rchk("status", `MIS_REG_STATUS, 32'h0000_0040);
    wreg(`MIS_REG_STATUS, 32'h0000_0000);
    @(posedge clk);
    raise <= 1'b1;
    @(posedge clk);
    raise <= 1'b0;
    repeat (4) @(posedge clk);
    chk("ack_early", 32'h0000_0000, {28'h000_0000, ack_cnt});
    exec(OP_CALL, 11'h300);
    exec(OP_ISR_EXIT, 11'h000);
    rchk("pc", `MIS_REG_PC, `MIS_IRQ_VECTOR);
    chk("ack", 32'h0000_0001, {28'h000_0000, ack_cnt});
    exec(OP_ISR_EXIT, 11'h000);
    rchk("pc", `MIS_REG_PC, 32'h0000_0042);
    chk("ack_once", 32'h0000_0001, {28'h000_0000, ack_cnt});
  endtask

  task automatic t_halt();
    wreg(`MIS_REG_STATUS, 32'h0000_0000);
    wreg(`MIS_REG_ACC, 32'h0000_0011);
    exec(OP_HALT, 11'h000);
    repeat (2) @(posedge clk);
    chk("clk_run", 32'h0000_0000, {31'h0, clk_run});
    rchk("status", `MIS_REG_STATUS, 32'h0000_0090);
    rchk("wdt", `MIS_REG_WDT, 32'h0000_0000);
    exec(OP_PLUS_ACC, 11'h010);
    rchk("acc", `MIS_REG_ACC, 32'h0000_0011);
    wreg(`MIS_REG_WAKE, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("clk_run", 32'h0000_0001, {31'h0, clk_run});
    rchk("wake", `MIS_REG_WAKE, 32'h0000_0000);
    repeat (700) @(posedge clk);
    bus(1'b0, `MIS_REG_WDT, 32'h0000_0000);
    chk("wdt_run", 32'h0000_0001, {31'h0, got !== 32'h0000_0000});
    exec(OP_WDT_CLEAR, 11'h000);
    rchk("wdt", `MIS_REG_WDT, 32'h0000_0000);
    rchk("status", `MIS_REG_STATUS, 32'h0000_0000);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    chk("wait_rst", 32'h0000_0001, {31'h0, wait_r});
    rst <= 1'b0;
    rchk("acc", `MIS_REG_ACC, 32'h0000_0000);
    rchk("pc", `MIS_REG_PC, 32'h0000_0000);
    rchk("status", `MIS_REG_STATUS, 32'h0000_0000);
    t_alu();
    t_flow();
    t_isr();
    t_halt();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[FAIL] timeout expected done seen running");
    conclude();
  end
endmodule
